// File: asss_pkg.sv
package asss_pkg;
    // command codes
    localparam logic [7:0] CMD_SHARED_START_PULSE = 8'h06;
    localparam logic [7:0] CMD_SHARED_STOP_PULSE = 8'h07;
    localparam logic [7:0] CMD_OWN_AXIS_START = 8'h2a;
    localparam logic [7:0] CMD_START = 8'h50;
    localparam logic [7:0] CMD_STOP = 8'h49;
    localparam logic [7:0] CMD_EMERGENCY_STOP = 8'h05;
    // register offsets
    localparam logic [3:0] ADDR_COMMAND = 4'h0;
    localparam logic [3:0] ADDR_MODE = 4'h1;
    localparam logic [3:0] ADDR_ENV1 = 4'h2;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h3;
    localparam logic [3:0] ADDR_EVENT_CAUSE = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;
    localparam logic [3:0] ADDR_ERROR_CAUSE = 4'h6;
    // field positions
    localparam int MODE_SYNC_LO = 18;
    localparam int MODE_SHARED_STOP_EN = 24;
    localparam int MODE_STOP_PULSE_FAULT = 25;
    localparam int MODE_PER_AXIS_PIN_MODE = 26;
    localparam int ENV1_START_TRIGGER = 18;
    localparam int ENV1_STOP_HANDLING = 19;
    localparam int ENV1_OWN_START_POL = 24;
    localparam int ENV1_START_PIN_SEL = 30;
    localparam int IRQ_START_EVENT = 18;
    localparam int CAUSE_START_EVENT = 19;
    localparam int STS_SHARED_START = 5;
    localparam int STS_SHARED_STOP = 6;
    localparam int STS_OWN_START = 8;
    localparam int ERR_SHARED_STOP = 8;
    localparam logic [1:0] SYNC_WAIT_START = 2'b01;
    // condition codes
    localparam logic [3:0] COND_STOPPED = 4'b0000;
    localparam logic [3:0] COND_WAIT_START = 4'b0010;
    localparam logic [3:0] COND_RUNNING = 4'b1000;
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int START_PULSE_NS = 400;
    localparam int PULSE_CYCLES = (START_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        ASSS_IDLE = 2'b00,
        ASSS_WAIT = 2'b01,
        ASSS_RUN = 2'b10
    } asss_state_t;

    typedef struct packed {
        logic start;
        logic stop_now;
        logic stop_decel;
    } asss_motion_t;
endpackage : asss_pkg

// File: asss_axis_sync.sv
`timescale 1ns/100ps
module asss_axis_sync
    import asss_pkg::*;
#(
    parameter int NUM_AXES = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [NUM_AXES-1:0] reg_axis_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // shared open-drain lines
    input wire logic shared_start_line_in,
    output logic shared_start_line_out,
    output logic shared_start_line_oe,
    input wire logic shared_stop_line_in,
    output logic shared_stop_line_out,
    output logic shared_stop_line_oe,
    // per-axis pins and motion side
    input wire logic [NUM_AXES-1:0] per_axis_start_pin,
    input wire logic [NUM_AXES-1:0] axis_fault_stop,
    input wire logic [NUM_AXES-1:0] axis_done,
    output asss_motion_t [NUM_AXES-1:0] axis_motion,
    output logic [NUM_AXES-1:0] irq_request
);

    // three-stage synchronisers for shared lines
    logic [2:0] sta_sync;
    logic [2:0] stp_sync;
    logic sta_low;
    logic sta_low_d;
    logic stp_low;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sta_sync <= 3'h7;
            stp_sync <= 3'h7;
            sta_low <= 1'b0;
            sta_low_d <= 1'b0;
            stp_low <= 1'b0;
        end else begin
            sta_sync <= {sta_sync[1:0], shared_start_line_in};
            stp_sync <= {stp_sync[1:0], shared_stop_line_in};
            if (sta_sync[1] == sta_sync[2]) begin
                sta_low <= ~sta_sync[2];
            end
            if (stp_sync[1] == stp_sync[2]) begin
                stp_low <= ~stp_sync[2];
            end
            sta_low_d <= sta_low;
        end
    end

    wire sta_fall = sta_low & ~sta_low_d;

    // command decode
    wire cmd_wr = reg_wr && (reg_addr == ADDR_COMMAND);
    wire [7:0] cmd_code = reg_wdata[7:0];
    wire cmd_start_pulse = cmd_wr && (cmd_code == CMD_SHARED_START_PULSE);
    wire cmd_stop_pulse = cmd_wr && (cmd_code == CMD_SHARED_STOP_PULSE);

    // one-shot pulse generators
    logic [3:0] sta_cnt;
    logic [3:0] stp_cnt;
    logic fault_pulse_req;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sta_cnt <= 4'h0;
            stp_cnt <= 4'h0;
        end else begin
            if (cmd_start_pulse && sta_cnt == 4'h0) begin
                sta_cnt <= 4'(PULSE_CYCLES);
            end else if (sta_cnt != 4'h0) begin
                sta_cnt <= sta_cnt - 4'h1;
            end
            if ((cmd_stop_pulse || fault_pulse_req) && stp_cnt == 4'h0) begin
                stp_cnt <= 4'(PULSE_CYCLES);
            end else if (stp_cnt != 4'h0) begin
                stp_cnt <= stp_cnt - 4'h1;
            end
        end
    end

    // open-drain drive: output low, enabled while pulling
    assign shared_start_line_out = 1'b0;
    assign shared_start_line_oe = (sta_cnt != 4'h0);
    assign shared_stop_line_out = 1'b0;
    assign shared_stop_line_oe = (stp_cnt != 4'h0);

    // per-axis logic
    logic [NUM_AXES-1:0] fault_emit;
    logic [31:0] axis_rdata [NUM_AXES];

    genvar g;
    generate
        for (g = 0; g < NUM_AXES; g++) begin : gen_axis
            logic [31:0] mode_reg;
            logic [31:0] env1_reg;
            logic [31:0] irq_en_reg;
            logic cause_start;
            logic err_stop;
            logic [2:0] pin_sync;
            logic own_raw;
            logic own_raw_d;
            asss_state_t state;
            asss_state_t next_state;
            logic [31:0] rd_q;

            wire sel = reg_axis_sel[g];
            wire pin_sel = env1_reg[ENV1_START_PIN_SEL];
            wire trig_edge = env1_reg[ENV1_START_TRIGGER];
            wire own_on = own_raw;
            wire own_rise = own_raw & ~own_raw_d;
            wire sync_wait = mode_reg[MODE_SYNC_LO+1:MODE_SYNC_LO] == SYNC_WAIT_START;
            wire stop_en = mode_reg[MODE_SHARED_STOP_EN];
            wire cmd_here = cmd_wr && sel;
            wire c_start = cmd_here && (cmd_code == CMD_START);
            wire c_own = cmd_here && (cmd_code == CMD_OWN_AXIS_START);
            wire c_stop = cmd_here && (cmd_code == CMD_STOP || cmd_code == CMD_EMERGENCY_STOP);
            wire shared_go = trig_edge ? sta_fall : sta_low;
            wire line_go = pin_sel ? own_on : shared_go;
            wire start_event = pin_sel ? own_rise : sta_fall;
            wire stop_hit = stop_en && stp_low && (state != ASSS_IDLE);
            wire stop_decel = env1_reg[ENV1_STOP_HANDLING];
            wire wr_mode = reg_wr && sel && reg_addr == ADDR_MODE;
            wire wr_env1 = reg_wr && sel && reg_addr == ADDR_ENV1;
            wire wr_irq = reg_wr && sel && reg_addr == ADDR_IRQ_EN;
            wire wr_cause = reg_wr && sel && reg_addr == ADDR_EVENT_CAUSE;
            wire wr_err = reg_wr && sel && reg_addr == ADDR_ERROR_CAUSE;
            wire [3:0] cond = (state == ASSS_WAIT) ? COND_WAIT_START :
                (state == ASSS_RUN) ? COND_RUNNING : COND_STOPPED;
            wire [31:0] status_word = {23'h0, own_on, 1'b0, stp_low, sta_low, 1'b0, cond};

            always_comb begin
                next_state = state;
                case (state)
                    ASSS_IDLE: begin
                        if (c_start) begin
                            next_state = sync_wait ? ASSS_WAIT : ASSS_RUN;
                        end
                    end
                    ASSS_WAIT: begin
                        if (c_stop || stop_hit) begin
                            next_state = ASSS_IDLE;
                        end else if (line_go || c_own) begin
                            next_state = ASSS_RUN;
                        end
                    end
                    ASSS_RUN: begin
                        if (c_stop || stop_hit || axis_done[g] || axis_fault_stop[g]) begin
                            next_state = ASSS_IDLE;
                        end
                    end
                    default: next_state = ASSS_IDLE;
                endcase
            end

            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    state <= ASSS_IDLE;
                    mode_reg <= RESET_WORD;
                    env1_reg <= RESET_WORD;
                    irq_en_reg <= RESET_WORD;
                    cause_start <= 1'b0;
                    err_stop <= 1'b0;
                    pin_sync <= 3'h0;
                    own_raw <= 1'b0;
                    own_raw_d <= 1'b0;
                    axis_motion[g] <= '0;
                    rd_q <= RESET_WORD;
                end else begin
                    state <= next_state;
                    pin_sync <= {pin_sync[1:0], per_axis_start_pin[g]};
                    if (pin_sync[1] == pin_sync[2]) begin
                        own_raw <= (pin_sync[2] == env1_reg[ENV1_OWN_START_POL]) && pin_sel;
                    end
                    own_raw_d <= own_raw;
                    if (wr_mode) mode_reg <= reg_wdata;
                    if (wr_env1) env1_reg <= reg_wdata;
                    if (wr_irq) irq_en_reg <= reg_wdata;
                    if (start_event) begin
                        cause_start <= 1'b1;
                    end else if (wr_cause && reg_wdata[CAUSE_START_EVENT]) begin
                        cause_start <= 1'b0;
                    end
                    if (stop_hit) begin
                        err_stop <= 1'b1;
                    end else if (wr_err && reg_wdata[ERR_SHARED_STOP]) begin
                        err_stop <= 1'b0;
                    end
                    axis_motion[g].start <= (next_state == ASSS_RUN) && (state != ASSS_RUN);
                    axis_motion[g].stop_now <= stop_hit && !stop_decel;
                    axis_motion[g].stop_decel <= stop_hit && stop_decel;
                    case (reg_addr)
                        ADDR_MODE: rd_q <= mode_reg;
                        ADDR_ENV1: rd_q <= env1_reg;
                        ADDR_IRQ_EN: rd_q <= irq_en_reg;
                        ADDR_EVENT_CAUSE: rd_q <= 32'(cause_start) << CAUSE_START_EVENT;
                        ADDR_STATUS: rd_q <= status_word;
                        ADDR_ERROR_CAUSE: rd_q <= 32'(err_stop) << ERR_SHARED_STOP;
                        default: rd_q <= RESET_WORD;
                    endcase
                end
            end

            assign irq_request[g] = cause_start && irq_en_reg[IRQ_START_EVENT];
            assign fault_emit[g] = axis_fault_stop[g] && mode_reg[MODE_STOP_PULSE_FAULT]
                && (state == ASSS_RUN);
            assign axis_rdata[g] = rd_q;
        end
    endgenerate

    assign fault_pulse_req = |fault_emit;

    // read data: lowest selected axis, one cycle after strobe
    logic rd_d;
    logic [NUM_AXES-1:0] sel_d;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_d <= 1'b0;
            sel_d <= '0;
        end else begin
            rd_d <= reg_rd;
            sel_d <= reg_axis_sel;
        end
    end

    always_comb begin
        reg_rdata = 32'h0000_0000;
        for (int i = NUM_AXES - 1; i >= 0; i--) begin
            if (rd_d && sel_d[i]) begin
                reg_rdata = axis_rdata[i];
            end
        end
    end

endmodule : asss_axis_sync

// File: asss_axis_sync_asserts.sv
`timescale 1ns/100ps
module asss_axis_sync_asserts
    import asss_pkg::*;
#(
    parameter int NUM_AXES = 4
) (
    // clock, reset, bus
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    // lines and motion
    input wire logic shared_start_line_out,
    input wire logic shared_start_line_oe,
    input wire logic shared_stop_line_out,
    input wire logic shared_stop_line_oe,
    input wire asss_motion_t [NUM_AXES-1:0] axis_motion
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic cmd_wr = reg_wr && reg_addr == ADDR_COMMAND;
    wire logic wr_sta = cmd_wr && reg_wdata[7:0] == CMD_SHARED_START_PULSE;
    wire logic wr_stp = cmd_wr && reg_wdata[7:0] == CMD_SHARED_STOP_PULSE;
    wire logic wr_own = cmd_wr && reg_wdata[7:0] == CMD_OWN_AXIS_START;
    wire logic own_start_input = shared_start_line_oe;
    wire logic stp = shared_stop_line_oe;

    a_start_width: assert property ($rose(own_start_input) |-> own_start_input [*8] ##1 !own_start_input)
        else $error("start pulse width wrong");
    a_start_cmd: assert property (wr_sta && !own_start_input |=> own_start_input)
        else $error("start pulse not launched");
    a_start_cause: assert property ($rose(own_start_input) |-> $past(wr_sta))
        else $error("start pulse without its command");
    a_own_no_pulse: assert property (wr_own && !own_start_input |=> !own_start_input)
        else $error("own start drove shared line");
    a_stop_width: assert property ($rose(stp) |-> stp [*8] ##1 !stp)
        else $error("stop pulse width wrong");
    a_stop_cmd: assert property (wr_stp && !stp |=> stp)
        else $error("stop pulse not launched");
    a_open_drain: assert property (!shared_start_line_out && !shared_stop_line_out)
        else $error("open drain line driven high");
    a_stop_excl: assert property (!(axis_motion[0].stop_now && axis_motion[0].stop_decel))
        else $error("both stop kinds at once");

    c_start_pulse: cover property ($rose(own_start_input));
    c_stop_pulse: cover property ($rose(stp));
    c_axis_start: cover property (axis_motion[0].start);
endmodule : asss_axis_sync_asserts

// File: asss_partner.sv
`timescale 1ns/100ps
module asss_partner (
    // clock and requests
    input wire logic sys_clk,
    input wire logic start_req,
    input wire logic stop_req,
    input wire logic [7:0] width,
    // open-drain pulls
    output logic start_pull,
    output logic stop_pull
);
    logic [7:0] sta_cnt = 8'h00;
    logic [7:0] stp_cnt = 8'h00;
    assign start_pull = sta_cnt != 8'h00;
    assign stop_pull = stp_cnt != 8'h00;
    always_ff @(posedge sys_clk) begin
        sta_cnt <= start_req ? width : sta_cnt - {7'h00, start_pull};
        stp_cnt <= stop_req ? width : stp_cnt - {7'h00, stop_pull};
    end
endmodule : asss_partner

// File: asss_axis_sync_tb.sv
`timescale 1ns/100ps
module asss_axis_sync_tb;
    import asss_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [3:0] reg_axis_sel = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic sta_oe, stp_oe, sta_pull, stp_pull, start_req = 1'b0, stop_req = 1'b0, rd_d = 1'b0;
    logic [7:0] width = 8'h04;
    logic [3:0] pin = 4'h0, done = 4'h0, irq;
    logic [3:0] fault = 4'h0;
    logic [1:0] seen = 2'b00;
    asss_motion_t [3:0] motion;
    int error_cnt = 0, compares = 0, cycles = 0, seed = 90;
    logic [31:0] exp_q[$];
    initial forever #25 sys_clk = ~sys_clk;
    asss_axis_sync #(.NUM_AXES(4)) i_asss_axis_sync (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_axis_sel(reg_axis_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .shared_start_line_in(~(sta_oe | sta_pull)), .shared_start_line_out(),
        .shared_start_line_oe(sta_oe), .shared_stop_line_in(~(stp_oe | stp_pull)), .shared_stop_line_out(),
        .shared_stop_line_oe(stp_oe), .per_axis_start_pin(pin), .axis_fault_stop(fault), .axis_done(done),
        .axis_motion(motion), .irq_request(irq));
    asss_partner i_asss_partner (.sys_clk(sys_clk), .start_req(start_req), .stop_req(stop_req),
        .width(width), .start_pull(sta_pull), .stop_pull(stp_pull));
    task automatic results();
        if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    always @(posedge sys_clk) begin
        rd_d <= reg_rd;
        cycles <= cycles + 1;
        if (motion[0].stop_now) seen[0] <= 1'b1;
        if (motion[0].stop_decel) seen[1] <= 1'b1;
        if (cycles > 20000) begin
            error_cnt++;
            results();
        end
    end
    always @(negedge sys_clk) if (rd_d) chk("rdata", reg_rdata, exp_q.pop_front());
    task automatic wr(input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_axis_sel <= s;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [3:0] s, input logic [31:0] e);
        @(posedge sys_clk);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_axis_sel <= s;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask : rd
    task automatic cmd(input logic [3:0] s, input logic [7:0] c);
        wr(ADDR_COMMAND, s, {24'h0, c});
    endtask : cmd
    task automatic ext(input logic stp, input logic [3:0] p);
        @(posedge sys_clk);
        width <= 8'h04 + 8'($random(seed) & 3);
        stop_req <= stp;
        start_req <= !stp;
        pin <= p;
        @(posedge sys_clk);
        stop_req <= 1'b0;
        start_req <= 1'b0;
        repeat (4) @(posedge sys_clk);
        pin <= 4'h0;
        repeat (16) @(posedge sys_clk);
    endtask : ext
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        for (int a = 1; a < 8; a++) rd(a[3:0], 4'h1, RESET_WORD);
        wr(4'hf, 4'hf, $random(seed));
        rd(4'hf, 4'h1, 32'h0);
        wr(ADDR_MODE, 4'hf, 32'h0004_0000);
        wr(ADDR_IRQ_EN, 4'h1, 32'h0004_0000);
        cmd(4'h3, CMD_START);
        rd(ADDR_STATUS, 4'h1, {28'h0, COND_WAIT_START});
        rd(ADDR_STATUS, 4'h2, {28'h0, COND_WAIT_START});
        rd(ADDR_STATUS, 4'h4, {28'h0, COND_STOPPED});
        cmd(4'h1, CMD_SHARED_START_PULSE);
        repeat (20) @(posedge sys_clk);
        rd(ADDR_STATUS, 4'h3, {28'h0, COND_RUNNING});
        rd(ADDR_STATUS, 4'h2, {28'h0, COND_RUNNING});
        rd(ADDR_EVENT_CAUSE, 4'h2, 32'h0008_0000);
        chk("irq", {28'h0, irq}, 32'h1);
        wr(ADDR_EVENT_CAUSE, 4'hf, 32'h0008_0000);
        rd(ADDR_EVENT_CAUSE, 4'h1, 32'h0);
        @(posedge sys_clk);
        done <= 4'h3;
        @(posedge sys_clk);
        done <= 4'h0;
        cmd(4'hc, CMD_START);
        cmd(4'h4, CMD_OWN_AXIS_START);
        cmd(4'h8, CMD_STOP);
        rd(ADDR_STATUS, 4'h4, {28'h0, COND_RUNNING});
        rd(ADDR_STATUS, 4'h8, {28'h0, COND_STOPPED});
        wr(ADDR_ENV1, 4'h2, 32'h4100_0000);
        cmd(4'h2, CMD_START);
        ext(1'b0, 4'h0);
        rd(ADDR_STATUS, 4'h2, {28'h0, COND_WAIT_START});
        rd(ADDR_EVENT_CAUSE, 4'h2, 32'h0);
        ext(1'b0, 4'h2);
        rd(ADDR_STATUS, 4'h2, {28'h0, COND_RUNNING});
        rd(ADDR_EVENT_CAUSE, 4'h2, 32'h0008_0000);
        for (int h = 0; h < 2; h++) begin
            wr(ADDR_MODE, 4'h1, 32'h0100_0000);
            wr(ADDR_ENV1, 4'h1, h << 19);
            seen <= 2'b00;
            cmd(4'h1, CMD_START);
            if (h == 0) ext(1'b1, 4'h0);
            else cmd(4'h1, CMD_SHARED_STOP_PULSE);
            repeat (20) @(posedge sys_clk);
            rd(ADDR_STATUS, 4'h1, {28'h0, COND_STOPPED});
            rd(ADDR_ERROR_CAUSE, 4'h1, 32'h0000_0100);
            wr(ADDR_ERROR_CAUSE, 4'h1, 32'h0000_0100);
            chk("stop kind", {30'h0, seen}, (h == 0) ? 32'h1 : 32'h2);
        end
        wr(ADDR_MODE, 4'h2, 32'h0100_0000);
        wr(ADDR_MODE, 4'h1, 32'h0200_0000);
        cmd(4'h1, CMD_START);
        @(posedge sys_clk);
        fault <= 4'h1;
        @(posedge sys_clk);
        fault <= 4'h0;
        repeat (20) @(posedge sys_clk);
        rd(ADDR_STATUS, 4'h2, {28'h0, COND_STOPPED});
        rd(ADDR_ERROR_CAUSE, 4'h2, 32'h0000_0100);
        repeat (4) @(posedge sys_clk);
        results();
    end
endmodule : asss_axis_sync_tb

bind asss_axis_sync asss_axis_sync_asserts #(.NUM_AXES(NUM_AXES)) i_asss_axis_sync_asserts (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .shared_start_line_out(shared_start_line_out), .shared_start_line_oe(shared_start_line_oe),
    .shared_stop_line_out(shared_stop_line_out), .shared_stop_line_oe(shared_stop_line_oe),
    .axis_motion(axis_motion));
